// file: logic/dka_access.sv
// Purpose: key-protected access control of the single wire debug port
// Assumes: link layer hands over decoded control-space and bus requests
// Notes:   control-space reads answer one cycle after the strobe
//
// Overview of operation
// - locked flag reads 0 when erase completes
// - erase failed flag reports erase outcome
// - locked part refuses system bus accesses, except user row writes
// - brown-out detector forced on during erase
// - programming active flag set when allowed
// - user row flag set after key, reset, on a locked part only
// - user row writes only first 64 bytes
// - buffer copied to user row one-to-one
// - load-done write copies, then clears flag
// - no ram reads in user row mode
// - sync edges produce an event pulse one cycle later
// - bus blocked when system clock stopped
// - sleep flag shows system domain sleeping
// - clock request keeps bus alive in sleep
// - clock request defaults to one when enabled
// - reset asserted while request holds 0x59
// - system reset leaves this block intact
// - keys exactly 64 bits, lsb first
`timescale 1ns/1ns
`include "dka_map.svh"
module dka_access #(
    parameter int UROW_DEPTH = 64,
    parameter int UROW_AW = 6
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // control space from the link layer
    input wire logic cs_we_i,
    input wire logic cs_re_i,
    input wire logic [3:0] cs_addr_i,
    input wire dka_pkg::dka_byte_t cs_wdata_i,
    output dka_pkg::dka_byte_t cs_rdata_o,
    // key frames
    input wire logic key_start_i,
    input wire logic key_valid_i,
    input wire dka_pkg::dka_byte_t key_byte_i,
    // link error report and sync edges
    input wire logic link_err_i,
    input wire logic [2:0] link_err_code_i,
    input wire logic sync_rise_i,
    // system bus requests from the link layer
    input wire logic sb_req_i,
    input wire logic sb_we_i,
    input wire logic [15:0] sb_addr_i,
    input wire dka_pkg::dka_byte_t sb_wdata_i,
    output logic sb_ack_o,
    output logic sb_err_o,
    output dka_pkg::dka_byte_t sb_rdata_o,
    // system bus towards memories and peripherals
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [15:0] mem_addr_o,
    output dka_pkg::dka_byte_t mem_wdata_o,
    input wire logic mem_ack_i,
    input wire dka_pkg::dka_byte_t mem_rdata_i,
    // system state
    input wire logic lock_bits_i,
    input wire logic erase_done_i,
    input wire logic erase_fail_i,
    input wire logic sys_sleep_i,
    input wire logic [2:0] crc_status_i,
    // controls out
    output logic sys_reset_o,
    output logic erase_start_o,
    output logic bod_force_o,
    output logic clk_request_o,
    output logic sync_event_o,
    output dka_pkg::dka_byte_t phy_ctrl_a_o,
    output logic [2:0] phy_ctrl_b_o,
    output logic [1:0] clk_sel_o,
    output logic row_wr_o,
    output logic [UROW_AW-1:0] row_addr_o,
    output dka_pkg::dka_byte_t row_data_o
);
    import dka_pkg::*;

    // ----
    // state
    // ----
    logic erase_key_q, prog_key_q, urow_key_q;  // decoded keys
    logic [7:0] rst_code_q;      // reset request register
    logic rst_prev_q;            // reset seen last cycle
    logic erase_busy_q;          // erase running
    logic erase_fail_q;          // sticky outcome
    logic prog_act_q;            // programming session open
    logic urow_act_q;            // user row session open
    logic sys_clock_request_q;              // system clock request bit
    logic [2:0] err_q;           // link error signature
    dka_bus_state_t bus_q;
    logic erase_hit, prog_hit, urow_hit;
    logic copy_busy, copy_done;

    // ----
    // decode, continuous
    // ----
    wire wr_w = cs_we_i;
    wire wr_phya = wr_w && (cs_addr_i == `DKA_OFS_PHYA);
    wire wr_phyb = wr_w && (cs_addr_i == `DKA_OFS_PHYB);
    wire wr_keys = wr_w && (cs_addr_i == `DKA_OFS_KEYSTAT);
    wire wr_rst = wr_w && (cs_addr_i == `DKA_OFS_RESET_REQUEST_CODE);
    wire wr_csel = wr_w && (cs_addr_i == `DKA_OFS_CLKSEL);
    wire wr_sctl = wr_w && (cs_addr_i == `DKA_OFS_SYSCTL);
    wire rd_err = cs_re_i && (cs_addr_i == `DKA_OFS_LNKERR);
    wire disable_w = phy_ctrl_b_o[`DKA_PB_DISABLE];
    // new reset value: only the code holds the system in reset
    wire [7:0] code_d = wr_rst ? cs_wdata_i : rst_code_q;
    wire rst_on_w = (rst_code_q == `DKA_RESET_CODE);
    wire rst_rel_w = rst_prev_q && !rst_on_w;         // release edge
    wire rst_rise_w = !rst_prev_q && rst_on_w;
    wire locked_w = lock_bits_i || erase_busy_q;
    wire sleep_block_w = sys_sleep_i && !clk_request_o;
    wire done_wr_w = wr_sctl && cs_wdata_i[`DKA_SC_USER_ROW_LOAD_DONE];
    // user row window: address fits the buffer
    wire in_win_w = (sb_addr_i < 16'(UROW_DEPTH));
    wire urow_wr_w = sb_req_i && (bus_q == DKA_BUS_IDLE) && urow_act_q
        && sb_we_i && in_win_w;
    // normal access needs unlocked, awake, out of reset
    wire bus_ok_w = !locked_w && !sleep_block_w && !rst_on_w
        && !urow_act_q;

    wire [7:0] keys_w = {2'b00, urow_key_q, prog_key_q, erase_key_q, 3'b000};
    wire [7:0] stat_w = {2'b00, rst_on_w, sys_sleep_i, prog_act_q,
        urow_act_q, erase_fail_q, locked_w};
    logic [7:0] rd_w;
    always_comb begin
        case (cs_addr_i)
            `DKA_OFS_REV: rd_w = `DKA_RST_REV;
            `DKA_OFS_LNKERR: rd_w = {5'b00000, err_q};
            `DKA_OFS_PHYA: rd_w = phy_ctrl_a_o;
            `DKA_OFS_PHYB: rd_w = {3'b000, phy_ctrl_b_o, 2'b00};
            `DKA_OFS_KEYSTAT: rd_w = keys_w;
            `DKA_OFS_RESET_REQUEST_CODE: rd_w = rst_code_q;
            `DKA_OFS_CLKSEL: rd_w = {6'b000000, clk_sel_o};
            `DKA_OFS_SYSCTL: rd_w = {7'b0000000, sys_clock_request_q};
            `DKA_OFS_SYSSTAT: rd_w = stat_w;
            `DKA_OFS_CRC: rd_w = {5'b00000, crc_status_i};
            default: rd_w = 8'h00;                    // unmapped reads zero
        endcase
    end

    // ----
    // key collector and user row buffer
    // ----
    dka_key_shift u_keys (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i && !disable_w),
        .key_start_i(key_start_i),
        .key_valid_i(key_valid_i),
        .key_byte_i(key_byte_i),
        .erase_hit_o(erase_hit),
        .prog_hit_o(prog_hit),
        .urow_hit_o(urow_hit)
    );

    dka_urow_buf #(
        .DEPTH(UROW_DEPTH),
        .AW(UROW_AW)
    ) u_urow (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(urow_wr_w),
        .wr_addr_i(sb_addr_i[UROW_AW-1:0]),
        .wr_data_i(sb_wdata_i),
        .copy_start_i(done_wr_w && urow_act_q),
        .row_wr_o(row_wr_o),
        .row_addr_o(row_addr_o),
        .row_data_o(row_data_o),
        .busy_o(copy_busy),
        .done_o(copy_done)
    );

    // ----
    // plain control registers
    // ----
    // not touched by the system reset it requests
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            phy_ctrl_a_o <= 8'h00;
            phy_ctrl_b_o <= 3'b000;
            clk_sel_o <= `DKA_RST_CLKSEL;
            rst_code_q <= 8'h00;
            rst_prev_q <= 1'b0;
        end else begin
            rst_prev_q <= rst_on_w;
            if (wr_phya) begin
                phy_ctrl_a_o <= {cs_wdata_i[7], 1'b0, cs_wdata_i[5:0]};
            end
            if (wr_phyb) begin
                phy_ctrl_b_o <= cs_wdata_i[4:2];
            end
            if (disable_w) begin                      // disable resets setup
                clk_sel_o <= `DKA_RST_CLKSEL;
                rst_code_q <= 8'h00;
            end else begin
                if (wr_csel) begin
                    clk_sel_o <= cs_wdata_i[1:0];
                end
                rst_code_q <= code_d;
            end
        end
    end

    // clock request: set whenever the port is (re)enabled
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || disable_w) begin
            sys_clock_request_q <= 1'b1;
        end else if (wr_sctl) begin
            sys_clock_request_q <= cs_wdata_i[`DKA_SC_SYS_CLOCK_REQUEST];
        end
    end

    // ----
    // keys and sessions
    // ----
    // decode sets win over clears in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || disable_w) begin
            erase_key_q <= 1'b0;
            prog_key_q <= 1'b0;
            urow_key_q <= 1'b0;
            prog_act_q <= 1'b0;
            urow_act_q <= 1'b0;
        end else begin
            // erase key is consumed by the reset request
            erase_key_q <= erase_hit || (erase_key_q && !rst_rise_w);
            // programming key consumed when session opens
            prog_key_q <= prog_hit
                || (prog_key_q && !(rst_rel_w && !locked_w));
            // user row key cleared by a write of its status bit
            urow_key_q <= urow_hit
                || (urow_key_q && !(wr_keys && cs_wdata_i[`DKA_KS_UROW]));
            if (rst_rise_w) begin
                prog_act_q <= 1'b0;
            end else if (rst_rel_w && prog_key_q && !locked_w) begin
                prog_act_q <= 1'b1;
            end
            if (copy_done) begin
                urow_act_q <= 1'b0;
            end else if (rst_rel_w && urow_key_q && lock_bits_i) begin
                urow_act_q <= 1'b1;
            end
        end
    end

    // ----
    // chip erase
    // ----
    // erase starts at the reset pulse carrying the erase key
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            erase_busy_q <= 1'b0;
            erase_fail_q <= 1'b0;
            erase_start_o <= 1'b0;
            bod_force_o <= 1'b0;
        end else begin
            erase_start_o <= rst_rise_w && erase_key_q;
            if (rst_rise_w && erase_key_q) begin
                erase_busy_q <= 1'b1;
                erase_fail_q <= 1'b0;
            end else if (erase_done_i) begin
                erase_busy_q <= 1'b0;
                erase_fail_q <= erase_fail_i;
            end
            // fuse and detector level stay with the detector itself
            bod_force_o <= (rst_rise_w && erase_key_q)
                || (erase_busy_q && !erase_done_i);
        end
    end

    // ----
    // link error signature, cleared by read
    // ----
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            err_q <= 3'b000;
        end else if (link_err_i) begin
            err_q <= link_err_code_i;                 // new error wins
        end else if (rd_err) begin
            err_q <= 3'b000;
        end
    end

    // ----
    // registered outputs
    // ----
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cs_rdata_o <= 8'h00;
            sys_reset_o <= 1'b0;
            clk_request_o <= 1'b0;
            sync_event_o <= 1'b0;
        end else begin
            if (cs_re_i) begin
                cs_rdata_o <= rd_w;
            end
            sys_reset_o <= (code_d == `DKA_RESET_CODE) && !disable_w;
            clk_request_o <= sys_clock_request_q && !disable_w;
            sync_event_o <= sync_rise_i;
        end
    end

    // ----
    // system bus sequencer
    // ----
    // one access in flight; refusals answer next cycle with error
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            bus_q <= DKA_BUS_IDLE;
            sb_ack_o <= 1'b0;
            sb_err_o <= 1'b0;
            sb_rdata_o <= 8'h00;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 16'h0000;
            mem_wdata_o <= 8'h00;
        end else begin
            sb_ack_o <= 1'b0;
            mem_req_o <= 1'b0;
            case (bus_q)
                DKA_BUS_IDLE: begin
                    if (sb_req_i && urow_act_q) begin
                        // writes outside window dropped without error
                        sb_ack_o <= 1'b1;
                        sb_err_o <= !sb_we_i || copy_busy;
                        sb_rdata_o <= 8'h00;
                    end else if (sb_req_i && bus_ok_w) begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= sb_we_i;
                        mem_addr_o <= sb_addr_i;
                        mem_wdata_o <= sb_wdata_i;
                        bus_q <= DKA_BUS_WAIT;
                    end else if (sb_req_i) begin
                        sb_ack_o <= 1'b1;
                        sb_err_o <= 1'b1;
                        sb_rdata_o <= 8'h00;
                    end
                end
                DKA_BUS_WAIT: begin
                    if (mem_ack_i) begin
                        sb_rdata_o <= mem_we_o ? 8'h00 : mem_rdata_i;
                        sb_err_o <= 1'b0;
                        sb_ack_o <= 1'b1;
                        bus_q <= DKA_BUS_IDLE;
                    end
                end
                default: bus_q <= DKA_BUS_IDLE;
            endcase
        end
    end
endmodule : dka_access

// file: logic/dka_map.svh
// Purpose: register offsets, field positions, reset values and key codes
// Assumes: control-space registers are 8 bits wide at 4-bit offsets
// Notes:   definitions only
`ifndef DKA_MAP_SVH
`define DKA_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DKA_OFS_REV      4'h0
`define DKA_OFS_LNKERR   4'h1
`define DKA_OFS_PHYA     4'h2
`define DKA_OFS_PHYB     4'h3
`define DKA_OFS_KEYSTAT  4'h7
`define DKA_OFS_RESET_REQUEST_CODE   4'h8
`define DKA_OFS_CLKSEL   4'h9
`define DKA_OFS_SYSCTL   4'hA
`define DKA_OFS_SYSSTAT  4'hB
`define DKA_OFS_CRC      4'hC

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DKA_KS_ERASE     3
`define DKA_KS_PROG      4
`define DKA_KS_UROW      5
`define DKA_PB_DISABLE   2
`define DKA_SC_SYS_CLOCK_REQUEST    0
`define DKA_SC_USER_ROW_LOAD_DONE  1
`define DKA_SS_LOCK      0
`define DKA_SS_EFAIL     1
`define DKA_SS_USER_ROW_PROG_ACTIVE  2
`define DKA_SS_PROG      3
`define DKA_SS_SLEEP     4
`define DKA_SS_SYSTEM_RESET_ACTIVE    5

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define DKA_RST_REV      8'h10
`define DKA_RST_CLKSEL   2'h3
`define DKA_RESET_CODE   8'h59
`define DKA_KEY_ERASE    64'h4E564D4572617365
`define DKA_KEY_PROG     64'h4E564D50726F6720
`define DKA_KEY_UROW     64'h4E564D5573267465
`define DKA_KEY_BYTES    4'h8

`endif

// file: logic/dka_pkg.sv
// Purpose: shared types of the key-protected access block
// Assumes: used with dka_map.svh
// Notes:   types only
package dka_pkg;
    // bus access sequencer
    typedef enum logic [1:0] {
        DKA_BUS_IDLE,
        DKA_BUS_WAIT,
        DKA_BUS_DONE
    } dka_bus_state_t;
    typedef logic [7:0] dka_byte_t;
endpackage : dka_pkg

// file: logic/dka_key_shift.sv
// Purpose: collect 64-bit activation keys and decode them
// Assumes: key bytes arrive one per strobe, least significant first
// Notes:   partial keys never match
`timescale 1ns/1ns
`include "dka_map.svh"
module dka_key_shift (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic key_start_i,
    input wire logic key_valid_i,
    input wire dka_pkg::dka_byte_t key_byte_i,
    output logic erase_hit_o,
    output logic prog_hit_o,
    output logic urow_hit_o
);
    import dka_pkg::*;

    // ----------------------------------------------------------------
    // shifter
    // ----------------------------------------------------------------
    logic [63:0] key_q;   // newest byte enters at the top
    logic [3:0] cnt_q;    // bytes taken so far
    wire last_w = key_valid_i && (cnt_q == `DKA_KEY_BYTES - 4'h1);
    wire [63:0] full_w = {key_byte_i, key_q[63:8]};

    // lsb first: eight shifts leave byte 0 at the bottom
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || key_start_i) begin
            cnt_q <= 4'h0;
            key_q <= 64'h0;
        end else if (key_valid_i) begin
            key_q <= full_w;
            cnt_q <= last_w ? 4'h0 : cnt_q + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // decode, one-cycle hit pulses
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            erase_hit_o <= 1'b0;
            prog_hit_o <= 1'b0;
            urow_hit_o <= 1'b0;
        end else begin
            erase_hit_o <= last_w && (full_w == `DKA_KEY_ERASE);
            prog_hit_o <= last_w && (full_w == `DKA_KEY_PROG);
            urow_hit_o <= last_w && (full_w == `DKA_KEY_UROW);
        end
    end
endmodule : dka_key_shift

// file: logic/dka_urow_buf.sv
// Purpose: staging buffer and copy engine for the user config row
// Assumes: writes are pre-filtered to the window by the caller
// Notes:   no read path exists on purpose
`timescale 1ns/1ns
module dka_urow_buf #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic copy_start_i,
    output logic row_wr_o,
    output logic [AW-1:0] row_addr_o,
    output logic [7:0] row_data_o,
    output logic busy_o,
    output logic done_o
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] mem_q [DEPTH];  // no reset, contents are don't-care
    logic [AW-1:0] ptr_q;       // copy pointer
    wire last_w = (ptr_q == AW'(DEPTH - 1));

    always_ff @(posedge sys_clk_i) begin
        if (wr_i && !busy_o) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // ----------------------------------------------------------------
    // copy engine: buffer offset n goes to row offset n
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            ptr_q <= '0;
            row_wr_o <= 1'b0;
            row_addr_o <= '0;
            row_data_o <= 8'h00;
        end else begin
            done_o <= 1'b0;
            row_wr_o <= busy_o;
            if (busy_o) begin
                row_addr_o <= ptr_q;
                row_data_o <= mem_q[ptr_q];
                ptr_q <= ptr_q + AW'(1);
                busy_o <= !last_w;
                done_o <= last_w;
            end else if (copy_start_i) begin
                busy_o <= 1'b1;
                ptr_q <= '0;
            end
        end
    end
endmodule : dka_urow_buf

// file: bench/dka_mem_model.sv
// Purpose: far-side memory and peripheral responder on the system bus
// Assumes: one outstanding request, address and data held until acknowledged
// Notes:   latency set at run time; idle read data toggles every cycle
`timescale 1ns/1ns
module dka_mem_model (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] lat_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    output logic mem_ack_o,
    output logic [7:0] mem_rdata_o
);
    logic [7:0] mem [0:255]; // byte store
    logic [3:0] cnt_q; // cycles left before the answer
    // ------------------------------------------------------------
    // responder: idle data is inverted so stale values never match
    // ------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (!rst_n_i) begin
            cnt_q <= 4'h0;
            mem_rdata_o <= 8'h00;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                mem_ack_o <= 1'b1;
                mem_rdata_o <= mem[mem_addr_i[7:0]];
            end
        end else if (mem_req_i === 1'b1) begin
            cnt_q <= lat_i;
            if (mem_we_i) mem[mem_addr_i[7:0]] <= mem_wdata_i;
        end
    end
endmodule : dka_mem_model

// file: bench/dka_access_chk.sv
// Purpose: port-level assertions of the key-protected access block
// Assumes: one clock, synchronous active-low reset
// Notes:   attached by bind from the bench top
`timescale 1ns/1ns
`include "dka_map.svh"
module dka_access_chk (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cs_we_i, sync_rise_i, sb_req_i, lock_bits_i, sys_sleep_i,
    input wire logic mem_ack_i, erase_done_i, mem_req_o, sb_ack_o, sb_err_o,
    input wire logic sys_reset_o, erase_start_o, bod_force_o, clk_request_o, sync_event_o,
    input wire logic [3:0] cs_addr_i,
    input wire dka_pkg::dka_byte_t cs_wdata_i
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------------------------------
    // reset request writes
    // ------------------------------------------------------------
    sequence s_code_wr;
        cs_we_i && cs_addr_i == `DKA_OFS_RESET_REQUEST_CODE && cs_wdata_i == `DKA_RESET_CODE;
    endsequence
    rst_set_a: assert property (s_code_wr |=> sys_reset_o) else $error("reset missing");
    rst_clear_a: assert property (cs_we_i && cs_addr_i == `DKA_OFS_RESET_REQUEST_CODE
        && cs_wdata_i != `DKA_RESET_CODE |=> !sys_reset_o) else $error("reset stuck");
    // ------------------------------------------------------------
    // bus gating: refusals answer the next cycle, no memory cycle
    // ------------------------------------------------------------
    lock_block_a: assert property (sb_req_i && lock_bits_i |=> sb_ack_o && !mem_req_o)
        else $error("locked access passed");
    sleep_block_a: assert property (sb_req_i && sys_sleep_i && !clk_request_o
        |=> sb_ack_o && sb_err_o) else $error("sleep access passed");
    mem_cause_a: assert property (mem_req_o |-> $past(sb_req_i)) else $error("stray mem req");
    mem_ack_a: assert property (mem_ack_i |=> sb_ack_o) else $error("ack lost");
    // ------------------------------------------------------------
    // events, clock request, brown-out forcing
    // ------------------------------------------------------------
    sync_evt_a: assert property (sync_rise_i |=> sync_event_o) else $error("no event");
    clk_req_a: assert property ($rose(rst_n_i) |=> clk_request_o) else $error("no sys_clock_request");
    bod_on_a: assert property (erase_start_o |-> ##[0:1] bod_force_o) else $error("bod off");
    bod_off_a: assert property (erase_done_i |-> ##[1:2] !bod_force_o) else $error("bod on");
endmodule : dka_access_chk

// file: bench/testbench.sv
// Purpose: self-checking bench of the key-protected access block
// Assumes: memory responder model on the system bus side
// Notes:   sessions run erase, sleep, programming and user row in turn
`timescale 1ns/1ns
`include "dka_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    import dka_pkg::*;
    logic sys_clk_i = 0, rst_n_i = 0, cs_we_i = 0, cs_re_i = 0, key_start_i = 0;
    logic key_valid_i = 0, link_err_i = 0, sync_rise_i = 0, sb_req_i = 0, sb_we_i = 0;
    logic lock_bits_i = 1, erase_done_i = 0, erase_fail_i = 0, sys_sleep_i = 0, mem_ack_i;
    logic sb_ack_o, sb_err_o, mem_req_o, mem_we_o, sys_reset_o, erase_start_o, bod_force_o;
    logic clk_request_o, sync_event_o, row_wr_o;
    logic [3:0] cs_addr_i = 0, lat = 1;
    logic [2:0] link_err_code_i = 0, crc_status_i = 3'h5;
    logic [15:0] sb_addr_i = 0, mem_addr_o;
    logic [5:0] row_addr_o;
    dka_byte_t cs_wdata_i = 0, key_byte_i = 0, sb_wdata_i = 0, cs_rdata_o, sb_rdata_o;
    dka_byte_t mem_wdata_o, mem_rdata_i, row_data_o, row [0:63];
    int failures = 0, total_checks = 0, rows = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    dka_access dka_access_i (.*, .phy_ctrl_a_o(), .phy_ctrl_b_o(), .clk_sel_o());
    dka_mem_model dka_mem_model_i (.sys_clk_i, .rst_n_i, .lat_i(lat), .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
    // collects the user row as it is copied out
    always @(posedge sys_clk_i) if (row_wr_o === 1'b1) begin
        row[row_addr_o] <= row_data_o;
        rows <= rows + 1;
    end
    // ----
    // access tasks
    // ----
    task cs_wr(input logic [3:0] a, input dka_byte_t d);
        @(posedge sys_clk_i) {cs_we_i, cs_addr_i, cs_wdata_i} <= {1'b1, a, d};
        @(posedge sys_clk_i) cs_we_i <= 1'b0;
    endtask : cs_wr
    task rd(input logic [3:0] a, input dka_byte_t x);
        @(posedge sys_clk_i) {cs_re_i, cs_addr_i} <= {1'b1, a};
        @(posedge sys_clk_i) cs_re_i <= 1'b0;
        @(posedge sys_clk_i) `CHK(cs_rdata_o, x)
    endtask : rd
    task sb(input logic w, input logic [15:0] a, input dka_byte_t d, input logic e,
        input dka_byte_t x);
        @(posedge sys_clk_i) {sb_req_i, sb_we_i, sb_addr_i, sb_wdata_i} <= {1'b1, w, a, d};
        @(posedge sys_clk_i) sb_req_i <= 1'b0;
        repeat (20) @(posedge sys_clk_i) if (sb_ack_o === 1'b1) break;
        `CHK({sb_ack_o, sb_err_o}, {1'b1, e})
        if (!w) `CHK(sb_rdata_o, x)
    endtask : sb
    // keys go least significant byte first; fewer than eight bytes must not decode
    task key(input logic [63:0] k, input int n);
        @(posedge sys_clk_i) key_start_i <= 1'b1;
        @(posedge sys_clk_i) key_start_i <= 1'b0;
        for (int i = 0; i < n; i++) @(posedge sys_clk_i) {key_valid_i, key_byte_i} <= {1'b1, k[8*i+:8]};
        @(posedge sys_clk_i) key_valid_i <= 1'b0;
    endtask : key
    task pulse;
        cs_wr(`DKA_OFS_RESET_REQUEST_CODE, `DKA_RESET_CODE);
        cs_wr(`DKA_OFS_RESET_REQUEST_CODE, 8'h00);
    endtask : pulse
    task final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    // ----
    // main sequence
    // ----
    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd(`DKA_OFS_REV, 8'h10);
        rd(`DKA_OFS_CLKSEL, 8'h03);
        rd(`DKA_OFS_CRC, 8'h05);
        sb(1'b1, 16'h0010, 8'h3C, 1'b1, 8'h00);
        key(`DKA_KEY_ERASE, 7);
        rd(`DKA_OFS_KEYSTAT, 8'h00);
        key(`DKA_KEY_ERASE, 8);
        rd(`DKA_OFS_KEYSTAT, 8'h08);
        cs_wr(`DKA_OFS_RESET_REQUEST_CODE, `DKA_RESET_CODE);
        rd(`DKA_OFS_SYSSTAT, 8'h21);
        `CHK({sys_reset_o, bod_force_o}, 2'b11)
        cs_wr(`DKA_OFS_RESET_REQUEST_CODE, 8'h00);
        rd(`DKA_OFS_SYSSTAT, 8'h01);
        @(posedge sys_clk_i) {erase_done_i, lock_bits_i} <= 2'b10;
        @(posedge sys_clk_i) erase_done_i <= 1'b0;
        rd(`DKA_OFS_SYSSTAT, 8'h00);
        `CHK({sys_reset_o, bod_force_o}, 2'b00)
        lat <= 4'h5;
        sb(1'b1, 16'h0010, 8'h3C, 1'b0, 8'h00);
        cs_wr(`DKA_OFS_SYSCTL, 8'h00);
        sys_sleep_i <= 1'b1;
        sb(1'b1, 16'h0010, 8'h00, 1'b1, 8'h00);
        rd(`DKA_OFS_SYSSTAT, 8'h10);
        cs_wr(`DKA_OFS_SYSCTL, 8'h01);
        sb(1'b0, 16'h0010, 8'h00, 1'b0, 8'h3C);
        sys_sleep_i <= 1'b0;
        key(`DKA_KEY_PROG, 8);
        pulse;
        rd(`DKA_OFS_SYSSTAT, 8'h08);
        pulse;
        rd(`DKA_OFS_SYSSTAT, 8'h00);
        @(posedge sys_clk_i) {sync_rise_i, link_err_i, link_err_code_i} <= 5'h1E;
        @(posedge sys_clk_i) {sync_rise_i, link_err_i, lock_bits_i} <= 3'b001;
        rd(`DKA_OFS_LNKERR, 8'h06);
        rd(`DKA_OFS_LNKERR, 8'h00);
        key(`DKA_KEY_UROW, 8);
        pulse;
        rd(`DKA_OFS_SYSSTAT, 8'h05);
        sb(1'b1, 16'h0000, 8'h11, 1'b0, 8'h00);
        sb(1'b1, 16'h0040, 8'h22, 1'b0, 8'h00);
        sb(1'b1, 16'h0005, 8'hA5, 1'b0, 8'h00);
        sb(1'b0, 16'h0005, 8'h00, 1'b1, 8'h00);
        cs_wr(`DKA_OFS_SYSCTL, 8'h03);
        repeat (80) @(posedge sys_clk_i);
        `CHK({rows[7:0], row[0], row[5]}, 24'h4011A5)
        rd(`DKA_OFS_SYSSTAT, 8'h01);
        cs_wr(`DKA_OFS_KEYSTAT, 8'h20);
        rd(`DKA_OFS_KEYSTAT, 8'h00);
        final_report;
    end
    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        failures++;
        final_report;
    end
endmodule : testbench
bind dka_access dka_access_chk dka_access_chk_i (.*);
